// [stp_raster_source.sv]
// Test-pattern raster source: stored pictures or zone plates onto the raster.
// Picture store answers pic_pix combinationally in the cycle pic_req is high.
`default_nettype none
`timescale 1ns/10ps

module stp_raster_source (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire stp_pkg::stp_cfg_t    cfg,
  input  wire logic                 src_zp,
  input  wire logic [11:0]          pic_w,
  input  wire logic [10:0]          pic_h,
  input  wire stp_pkg::stp_pix_t    pic_pix,
  input  wire stp_pkg::stp_pat_t    pat_sel,
  input  wire stp_pkg::stp_zp_cmd_t zp_cmd,
  input  wire logic [7:0]           pattern_amplitude_scale,
  output logic                      cfg_ok,
  output logic                      pic_req,
  output logic      [11:0]          pic_x,
  output logic      [10:0]          pic_y,
  output stp_pkg::stp_vid_t         vid
);
  import stp_pkg::*;

  typedef struct packed {
    stp_cfg_t          cfg;
    logic              ok;
    logic [11:0]       w;
    logic [10:0]       h;
    logic              scan2;
    logic [11:0]       x;
    logic [10:0]       y;
    logic              fld;
    logic [7:0]        t;
    logic              v1;
    logic              req1;
    logic              sol1;
    logic              sof1;
    logic              fld1;
    logic              inpic1;
    logic [11:0]       x1;
    logic [10:0]       y1;
    stp_pat_t          pat;
    logic              reload;
    logic [5:0][15:0]  ctrl;
    stp_coefs_t        coef;
    stp_coefs_t [1:0]  cust;
    stp_vid_t          vid;
  } stp_state_t;

  stp_state_t         q;
  stp_state_t         d;
  logic signed [31:0] ph;
  logic signed [31:0] sq;
  logic [11:0]        zp_lvl;
  logic [11:0]        ny;
  logic [11:0]        rem;
  logic [2:0]         e;
  logic               restart;
  stp_pix_t           blk;
  stp_pix_t           px;

  function automatic logic signed [31:0] term(
    input stp_coef_t   k,
    input logic [11:0] a,
    input logic [11:0] b
  );
    logic signed [47:0] p;
    p = 48'(k) * $signed({36'h0, a}) * $signed({36'h0, b});
    term = p[31:0];
  endfunction

  // Coefficient set that a predefined pattern derives from its control value
  function automatic stp_coefs_t derive(
    input stp_pat_t    p,
    input logic [15:0] c,
    input logic [11:0] w,
    input logic [10:0] h
  );
    logic signed [31:0] c32;
    logic signed [31:0] w32;
    logic signed [31:0] h32;
    logic signed [31:0] r;
    c32 = 32'($signed(c));
    w32 = $signed({20'h0, w});
    h32 = $signed({21'h0, h});
    r = '0;
    derive = '0;
    unique case (p)
      PAT_CIRCLE: begin
        // Curvature gives c at the top edge; linear terms recentre it
        r = (c32 <<< 1) / h32;
        derive[K_X2] = r[15:0];
        derive[K_Y2] = r[15:0];
        derive[K_X] = 16'(-(r * (w32 >>> 1)));
        derive[K_Y] = 16'(-(r * (h32 >>> 1)));
      end
      PAT_DIAG: begin
        derive[K_X] = c;
        derive[K_Y] = c;
      end
      PAT_HSINE: derive[K_X] = c;
      PAT_HSWEEP: begin
        r = c32 / w32;
        derive[K_X2] = r[15:0];
      end
      PAT_VSINE: derive[K_Y] = c;
      PAT_VSWEEP: begin
        r = c32 / h32;
        derive[K_Y2] = r[15:0];
      end
      PAT_CUSTOM1, PAT_CUSTOM2: derive = '0;
    endcase
  endfunction

  // Linear ramp over the first and last few samples of each line
  function automatic logic [11:0] shape(
    input logic [11:0] v,
    input logic [11:0] b,
    input logic [2:0]  wt
  );
    logic signed [16:0] df;
    df = ($signed({5'h0, v}) - $signed({5'h0, b})) * $signed({14'h0, wt});
    shape = 12'($signed({5'h0, b}) + (df >>> 2));
  endfunction

  stp_zp_sine u_sine (
    .phase  (ph[PH_LSB+9:PH_LSB]),
    .amp    (pattern_amplitude_scale),
    .deep12 (q.cfg.deep12),
    .level  (zp_lvl)
  );

  // Phase polynomial over the stage-1 coordinates
  always_comb begin
    sq = term(q.coef[K_X2], q.x1, q.x1)
       + term(q.coef[K_Y2], {1'b0, q.y1}, {1'b0, q.y1})
       + term(q.coef[K_T2], {4'h0, q.t}, {4'h0, q.t});
    ph = term(q.coef[K_PHI], 12'h001, 12'h001)
       + term(q.coef[K_X], q.x1, 12'h001)
       + term(q.coef[K_Y], {1'b0, q.y1}, 12'h001)
       + term(q.coef[K_T], {4'h0, q.t}, 12'h001)
       + term(q.coef[K_XT], q.x1, {4'h0, q.t})
       + term(q.coef[K_YT], {1'b0, q.y1}, {4'h0, q.t})
       + term(q.coef[K_XY], q.x1, {1'b0, q.y1})
       + (sq >>> 1);
  end

  always_comb begin
    d = q;
    ny = '0;
    rem = '0;
    e = '0;
    px = '0;
    blk = black_pix(q.cfg.st, q.cfg.deep12);

    d.cfg = cfg;
    d.ok = fmt_ok(cfg);
    d.w = act_w(cfg.fmt);
    d.h = act_h(cfg.fmt);
    d.scan2 = (cfg.rate >= R59I94);
    // Any format change restarts the raster from the top
    restart = (cfg != q.cfg) || !q.ok;

    // Raster walk: interlace and psf scan even lines, then odd lines
    if (restart) begin
      d.x = '0;
      d.y = '0;
      d.fld = 1'b0;
      d.reload = 1'b1;
    end else if (q.x == q.w - 12'h001) begin
      d.x = '0;
      ny = {1'b0, q.y} + (q.scan2 ? 12'h002 : 12'h001);
      if (ny >= {1'b0, q.h}) begin
        if (q.scan2 && !q.fld) begin
          d.y = 11'h001;
          d.fld = 1'b1;
        end else begin
          d.y = '0;
          d.fld = 1'b0;
          d.t = q.t + 8'h01;
        end
      end else begin
        d.y = ny[10:0];
      end
    end else begin
      d.x = q.x + 12'h001;
    end

    d.v1 = !restart;
    d.x1 = q.x;
    d.y1 = q.y;
    d.sol1 = (q.x == '0);
    d.sof1 = (q.x == '0) && (q.y == '0) && !q.fld;
    d.fld1 = q.fld;
    // Samples past the picture are never fetched
    d.inpic1 = (q.x < pic_w) && (q.y < pic_h);
    d.req1 = !restart && d.inpic1 && !src_zp;

    // Zone plate coefficient management
    if (pat_sel != q.pat) begin
      d.pat = pat_sel;
      d.reload = 1'b1;
    // A pending reload waits out a restart so it sees the new raster size
    end else if (q.reload && q.ok && !restart) begin
      d.reload = 1'b0;
      unique case (q.pat)
        PAT_CUSTOM1: d.coef = q.cust[0];
        PAT_CUSTOM2: d.coef = q.cust[1];
        default: d.coef = derive(q.pat, q.ctrl[q.pat], q.w, q.h);
      endcase
    end
    if (zp_cmd.ctrl_wr && !(q.pat inside {PAT_CUSTOM1, PAT_CUSTOM2})) begin
      d.ctrl[q.pat] = zp_cmd.ctrl_val;
      d.reload = 1'b1;
    end
    // A direct write stores the value only; no shape is enforced
    if (zp_cmd.coef_wr && zp_cmd.coef_idx <= K_T2) begin
      d.coef[zp_cmd.coef_idx] = zp_cmd.coef_val;
    end
    if (zp_cmd.save_wr) begin
      d.cust[zp_cmd.save_slot] = q.coef;
    end

    // Output stage
    if (src_zp) begin
      px.c0 = zp_lvl;
      px.c1 = (q.cfg.st inside {ST_YCC422, ST_YCC444}) ? blk.c1 : zp_lvl;
      px.c2 = (q.cfg.st inside {ST_YCC422, ST_YCC444}) ? blk.c2 : zp_lvl;
    end else begin
      px = q.inpic1 ? pic_pix : blk;
      rem = q.w - q.x1;
      if (q.x1 < EDGE_LEN) begin
        e = 3'(q.x1 + 12'h001);
      end else if (rem < EDGE_LEN) begin
        e = rem[2:0];
      end else begin
        e = EDGE_LEN[2:0];
      end
      // No other filtering: stressful edges inside the picture pass as stored
      px.c0 = shape(px.c0, blk.c0, e);
      px.c1 = shape(px.c1, blk.c1, e);
      px.c2 = shape(px.c2, blk.c2, e);
    end
    d.vid.valid = q.v1;
    d.vid.sof = q.v1 && q.sof1;
    d.vid.sol = q.v1 && q.sol1;
    d.vid.field = q.fld1;
    d.vid.pix = q.v1 ? px : blk;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.reload <= 1'b1;
      q.ctrl <= {6{CTRL_RST}};
    end else if (ce) begin
      q <= d;
    end
  end

  assign cfg_ok = q.ok;
  assign pic_req = q.req1;
  assign pic_x = q.x1;
  assign pic_y = q.y1;
  assign vid = q.vid;

endmodule
`default_nettype wire

// [stp_pkg.sv]
// Shared types, constants and format tables for the test-pattern raster source.
// Assumes a single 100 MHz clock and at most 12 bits per sample channel.
`default_nettype none
package stp_pkg;

  typedef enum logic [2:0] {
    FMT_SD525, FMT_SD625, FMT_HD720, FMT_HD1080,
    FMT_LB2X720, FMT_LB2X1080, FMT_LB2K1080
  } stp_fmt_t;

  // p = progressive, i = interlaced, f = segmented frame
  typedef enum logic [3:0] {
    R23P98, R24P, R25P, R29P97, R30P, R50P, R59P94, R60P,
    R59I94, R50I, R60I, R23F98, R24F, R25F, R29F97, R30F
  } stp_rate_t;

  typedef enum logic [1:0] {
    ST_YCC422, ST_YCC444, ST_GBR444, ST_XYZ444
  } stp_struct_t;

  typedef enum logic [2:0] {
    PAT_CIRCLE, PAT_DIAG, PAT_HSINE, PAT_HSWEEP,
    PAT_VSINE, PAT_VSWEEP, PAT_CUSTOM1, PAT_CUSTOM2
  } stp_pat_t;

  typedef struct packed {
    stp_fmt_t    fmt;
    stp_rate_t   rate;
    stp_struct_t st;
    logic        deep12;
  } stp_cfg_t;

  // c0 = Y/G, c1 = Cb/B, c2 = Cr/R
  typedef struct packed {
    logic [11:0] c0;
    logic [11:0] c1;
    logic [11:0] c2;
  } stp_pix_t;

  typedef struct packed {
    logic     valid;
    logic     sof;
    logic     sol;
    logic     field;
    stp_pix_t pix;
  } stp_vid_t;

  typedef logic signed [15:0] stp_coef_t;
  typedef stp_coef_t [9:0]    stp_coefs_t;

  typedef struct packed {
    logic        ctrl_wr;
    logic [15:0] ctrl_val;
    logic        coef_wr;
    logic [3:0]  coef_idx;
    logic [15:0] coef_val;
    logic        save_wr;
    logic        save_slot;
  } stp_zp_cmd_t;

  localparam logic [3:0] K_PHI = 4'h0;
  localparam logic [3:0] K_X   = 4'h1;
  localparam logic [3:0] K_Y   = 4'h2;
  localparam logic [3:0] K_T   = 4'h3;
  localparam logic [3:0] K_XT  = 4'h4;
  localparam logic [3:0] K_YT  = 4'h5;
  localparam logic [3:0] K_XY  = 4'h6;
  localparam logic [3:0] K_X2  = 4'h7;
  localparam logic [3:0] K_Y2  = 4'h8;
  localparam logic [3:0] K_T2  = 4'h9;

  localparam logic [15:0] CTRL_RST = 16'h0040;
  localparam int          PH_LSB   = 6;
  localparam logic [11:0] EDGE_LEN = 12'h004;

  localparam logic [11:0] W_SD   = 12'h2D0;
  localparam logic [11:0] W_720  = 12'h500;
  localparam logic [11:0] W_1080 = 12'h780;
  localparam logic [11:0] W_2K   = 12'h800;
  localparam logic [10:0] H_525  = 11'h1E6;
  localparam logic [10:0] H_625  = 11'h240;
  localparam logic [10:0] H_720  = 11'h2D0;
  localparam logic [10:0] H_1080 = 11'h438;

  localparam logic [11:0] BLK_Y10 = 12'h040;
  localparam logic [11:0] BLK_C10 = 12'h200;
  localparam logic [11:0] BLK_Y12 = 12'h100;
  localparam logic [11:0] BLK_C12 = 12'h800;
  localparam logic [9:0]  ZP_MID10 = 10'h200;
  localparam logic [9:0]  ZP_MIN10 = 10'h040;
  localparam logic [9:0]  ZP_MAX10 = 10'h3AC;

  function automatic logic fmt_ok(input stp_cfg_t c);
    logic ycc10;
    ycc10 = (c.st == ST_YCC422) && !c.deep12;
    unique case (c.fmt)
      FMT_SD525:    fmt_ok = ycc10 && (c.rate == R59I94);
      FMT_SD625:    fmt_ok = ycc10 && (c.rate == R50I);
      FMT_HD720:    fmt_ok = ycc10 && (c.rate <= R60P);
      FMT_LB2X720:  fmt_ok = ycc10 && (c.rate <= R60P);
      FMT_HD1080, FMT_LB2X1080:
        fmt_ok = ycc10 && !(c.rate inside {R50P, R59P94, R60P});
      FMT_LB2K1080:
        fmt_ok = c.deep12 && (c.st inside {ST_XYZ444, ST_GBR444})
                 && (c.rate <= R30P || c.rate >= R23F98);
      default:      fmt_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [11:0] act_w(input stp_fmt_t f);
    unique case (f)
      FMT_SD525, FMT_SD625:     act_w = W_SD;
      FMT_HD720, FMT_LB2X720:   act_w = W_720;
      FMT_LB2K1080:             act_w = W_2K;
      default:                  act_w = W_1080;
    endcase
  endfunction

  function automatic logic [10:0] act_h(input stp_fmt_t f);
    unique case (f)
      FMT_SD525:                act_h = H_525;
      FMT_SD625:                act_h = H_625;
      FMT_HD720, FMT_LB2X720:   act_h = H_720;
      default:                  act_h = H_1080;
    endcase
  endfunction

  // Nominal black of the selected structure and depth
  function automatic stp_pix_t black_pix(input stp_struct_t s, input logic d12);
    logic [11:0] y;
    logic [11:0] c;
    y = d12 ? BLK_Y12 : BLK_Y10;
    c = d12 ? BLK_C12 : BLK_C10;
    black_pix.c0 = y;
    black_pix.c1 = (s inside {ST_YCC422, ST_YCC444}) ? c : y;
    black_pix.c2 = (s inside {ST_YCC422, ST_YCC444}) ? c : y;
  endfunction

endpackage
`default_nettype wire

// [stp_zp_sine.sv]
// Sinusoid shaper for the zone plate: phase to luma code, amplitude scaled.
// Purely combinational; the instantiating module registers the result.
`default_nettype none
`timescale 1ns/10ps
module stp_zp_sine (
  input  wire logic [9:0]  phase,
  input  wire logic [7:0]  amp,
  input  wire logic        deep12,
  output logic      [11:0] level
);
  import stp_pkg::*;

  logic [8:0]  h;
  logic [18:0] q;
  logic [9:0]  mag;
  logic [18:0] s;
  logic [9:0]  lv;

  // Parabolic half-wave: within 6 % of a true sine, no table to store
  always_comb begin
    h   = phase[8:0];
    q   = 19'(h) * 19'(10'h200 - {1'b0, h});
    mag = q[16:7];
    s   = (19'(mag) * 19'({1'b0, amp} + 9'h001)) >> 8;
    if (phase[9]) begin
      lv = (s[9:0] > ZP_MID10 - ZP_MIN10) ? ZP_MIN10 : ZP_MID10 - s[9:0];
    end else begin
      lv = (s[9:0] > ZP_MAX10 - ZP_MID10) ? ZP_MAX10 : ZP_MID10 + s[9:0];
    end
    level = deep12 ? {lv, 2'b00} : {2'b00, lv};
  end

endmodule
`default_nettype wire

// [stp_raster_source_props.sv]
// Port-level checker for the raster source.
// Assumes one clock domain and is bound onto every raster source instance.
`timescale 1ns/10ps
`default_nettype none
module stp_raster_source_props
  import stp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire stp_cfg_t    cfg,
  input wire logic        src_zp,
  input wire logic [11:0] pic_w,
  input wire logic [10:0] pic_h,
  input wire logic        cfg_ok,
  input wire logic        pic_req,
  input wire logic [11:0] pic_x,
  input wire logic [10:0] pic_y,
  input wire stp_vid_t    vid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_bad;
    (!cfg_ok && ce)[*3];
  endsequence
  sequence s_ok_rise;
    ($rose(cfg_ok) && ce && $stable(cfg)) ##1 (ce && $stable(cfg));
  endsequence
  property p_refuse;
    s_bad |-> !vid.valid && !pic_req;
  endproperty
  property p_start;
    s_ok_rise |=> vid.valid && vid.sof;
  endproperty
  property p_hold;
    !ce |=> $stable(vid) && $stable(pic_x) && $stable(cfg_ok);
  endproperty
  property p_region;
    pic_req |-> pic_x < $past(pic_w) && pic_y < $past(pic_h) && !$past(src_zp);
  endproperty
  property p_sof;
    vid.sof |-> vid.sol && vid.valid && !vid.field;
  endproperty
  property p_sol_x;
    vid.sol && $past(ce) |-> $past(pic_x) == 12'h000;
  endproperty
  property p_sol_pulse;
    vid.sol && ce |=> !vid.sol;
  endproperty
  property p_field;
    vid.valid && !vid.sol |-> $stable(vid.field);
  endproperty
  property p_prog;
    vid.valid && cfg.rate < R59I94 && $past(cfg.rate, 4) == cfg.rate |-> !vid.field;
  endproperty
  a_refuse: assert property (p_refuse) else $error("video active on bad format");
  a_start: assert property (p_start) else $error("raster did not start");
  a_hold: assert property (p_hold) else $error("outputs moved with ce low");
  a_region: assert property (p_region) else $error("fetch outside picture");
  a_sof: assert property (p_sof) else $error("frame start malformed");
  a_sol_x: assert property (p_sol_x) else $error("line start not at x 0");
  a_sol_pulse: assert property (p_sol_pulse) else $error("line start too long");
  a_field: assert property (p_field) else $error("field changed mid line");
  a_prog: assert property (p_prog) else $error("field 1 on progressive");
endmodule
bind stp_raster_source stp_raster_source_props u_props (
  .clk(clk), .rstn(rstn), .ce(ce), .cfg(cfg), .src_zp(src_zp), .pic_w(pic_w),
  .pic_h(pic_h), .cfg_ok(cfg_ok), .pic_req(pic_req), .pic_x(pic_x), .pic_y(pic_y),
  .vid(vid)
);
`default_nettype wire

// [stp_pic_store.sv]
// Zero-latency picture store model facing the raster source.
// Assumes coordinates and request are settled shortly after the clock edge.
`timescale 1ns/10ps
`default_nettype none
module stp_pic_store
  import stp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        deep12,
  input  wire logic        pic_req,
  input  wire logic [11:0] pic_x,
  input  wire logic [10:0] pic_y,
  output stp_pix_t         pic_pix
);
  logic [11:0] base;
  logic        tog_q = 1'b0;
  always @(posedge clk) tog_q <= ~tog_q;
  // Samples sit at or above every black level so edge shaping never goes negative
  assign base = deep12 ? 12'h800 : 12'h200;
  // Unrequested cycles show a toggling pattern, never a stale sample
  assign pic_pix = pic_req ? {base + {4'h0, pic_x[7:0]}, base + {4'h0, pic_y[7:0]},
                              base + 12'h010} : {36{tog_q}};
endmodule
`default_nettype wire

// [test_sdi_test_pattern_raster_source.sv]
// Self-checking bench: format table, picture crop and pad, zone plates.
// Assumes the store model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module test_sdi_test_pattern_raster_source;
  import stp_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  stp_cfg_t    cfg = '0;
  logic        src_zp = 1'b0;
  logic [11:0] pic_w = '0;
  logic [10:0] pic_h = '0;
  stp_pat_t    pat_sel = PAT_CIRCLE;
  stp_zp_cmd_t zp_cmd = '0;
  logic [7:0]  amp = 8'hFF;
  stp_pix_t    pic_pix;
  logic        cfg_ok;
  logic        pic_req;
  logic [11:0] pic_x;
  logic [10:0] pic_y;
  stp_vid_t    vid;
  logic [31:0] seed = 32'hF4EEE12E;
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  stp_raster_source i_dut (.clk(clk), .rstn(rstn), .ce(ce), .cfg(cfg), .src_zp(src_zp),
    .pic_w(pic_w), .pic_h(pic_h), .pic_pix(pic_pix), .pat_sel(pat_sel), .zp_cmd(zp_cmd),
    .pattern_amplitude_scale(amp), .cfg_ok(cfg_ok), .pic_req(pic_req), .pic_x(pic_x),
    .pic_y(pic_y), .vid(vid));
  stp_pic_store i_store (.clk(clk), .deep12(cfg.deep12), .pic_req(pic_req),
    .pic_x(pic_x), .pic_y(pic_y), .pic_pix(pic_pix));

  always #5 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      stop_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic exp_ok(stp_cfg_t c);
    logic y10;
    y10 = c.st == ST_YCC422 && !c.deep12;
    case (c.fmt)
      FMT_SD525: return y10 && c.rate == R59I94;
      FMT_SD625: return y10 && c.rate == R50I;
      FMT_HD720, FMT_LB2X720: return y10 && c.rate <= R60P;
      FMT_HD1080, FMT_LB2X1080: return y10 && !(c.rate inside {R50P, R59P94, R60P});
      FMT_LB2K1080: return c.deep12 && c.st inside {ST_XYZ444, ST_GBR444}
                           && !(c.rate inside {[R50P:R60I]});
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [35:0] exp_pix(int x, int y, int w, int h, stp_cfg_t c, int wd);
    logic [35:0] b;
    logic [35:0] v;
    logic [35:0] r;
    logic [11:0] s;
    int wt;
    s = c.deep12 ? 12'h800 : 12'h200;
    b[35:24] = c.deep12 ? 12'h100 : 12'h040;
    b[23:12] = c.st inside {ST_GBR444, ST_XYZ444} ? b[35:24] : s;
    b[11:0] = b[23:12];
    if (x >= w || y >= h)
      return b;
    v = {s + 12'(x % 256), s + 12'(y % 256), s + 12'h010};
    wt = x < 4 ? x + 1 : (x >= wd - 4 ? wd - x : 4);
    for (int i = 0; i < 3; i++)
      r[i*12 +: 12] = 12'(int'(b[i*12 +: 12]) + int'(v[i*12 +: 12] - b[i*12 +: 12]) * wt / 4);
    return r;
  endfunction

  task automatic chk(string what, logic [36:0] exp, logic [36:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // An illegal step first, so every start is a real restart
  task automatic start(stp_cfg_t c, logic zp);
    int n;
    cfg = '1;
    src_zp = zp;
    tick();
    tick();
    cfg = c;
    n = 0;
    do begin
      tick();
      n++;
    end while (!(vid.valid === 1'b1 && vid.sof === 1'b1) && n < 20);
    chk("sof", 1, n < 20);
  endtask

  task automatic pic_run(stp_cfg_t c, int w, int h, int lines, int wd);
    int x;
    int k;
    logic e;
    pic_w = 12'(w);
    pic_h = 11'(h);
    start(c, 1'b0);
    x = 0;
    k = 0;
    while (k < lines) begin
      chk("pix", {1'b1, exp_pix(x, c.rate >= R59I94 ? 2 * k : k, w, h, c, wd)},
          {vid.valid, vid.pix});
      x++;
      if (x == wd) begin
        x = 0;
        k++;
      end
      // Random stalls; the last step leaves ce high for the next scenario
      do begin
        tick();
        e = ce;
        ce = k < lines ? rnd() % 8 != 0 : 1'b1;
      end while (!e);
    end
  endtask

  task automatic zp_line(logic [11:0] lo, logic [11:0] hi, logic wide);
    logic [11:0] mn;
    logic [11:0] mx;
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (vid.sol !== 1'b1 && n < 3000);
    mn = 12'hFFF;
    mx = 12'h000;
    repeat (720) begin
      if (vid.pix.c0 < mn)
        mn = vid.pix.c0;
      if (vid.pix.c0 > mx)
        mx = vid.pix.c0;
      tick();
    end
    chk("zp_range", 1, mn >= lo && mx <= hi);
    chk("zp_chroma", 12'h200, vid.pix.c1);
    if (wide)
      chk("zp_swing", 1, mx - mn > 12'h100);
  endtask

  task automatic zcmd(stp_zp_cmd_t z);
    zp_cmd = z;
    tick();
    zp_cmd = '0;
    tick();
  endtask

  // Zone plate level bounds: mid code +/- twice (amplitude + 1), clamped
  function automatic logic [11:0] zp_bound(logic [7:0] a, logic up);
    int mid;
    int dv;
    mid = int'(ZP_MID10);
    dv = 2 * (int'(a) + 1);
    if (up)
      return 12'(mid + dv > int'(ZP_MAX10) ? int'(ZP_MAX10) : mid + dv);
    return 12'(mid - dv < int'(ZP_MIN10) ? int'(ZP_MIN10) : mid - dv);
  endfunction

  localparam stp_cfg_t SD625 = '{FMT_SD625, R50I, ST_YCC422, 1'b0};
  logic [31:0] r;

  initial begin
    repeat (8) tick();
    rstn = 1'b1;
    for (int f = 0; f < 8; f++) begin
      for (int q = 0; q < 16; q++) begin
        cfg = '{stp_fmt_t'(f), stp_rate_t'(q), f == 6 ? ST_GBR444 : ST_YCC422, f == 6};
        tick();
        tick();
        chk("cfg_ok", exp_ok(cfg), cfg_ok);
      end
    end
    repeat (200) begin
      r = rnd();
      cfg = stp_cfg_t'(r[9:0]);
      tick();
      tick();
      chk("cfg_ok", exp_ok(cfg), cfg_ok);
    end
    pic_run('{FMT_SD525, R59I94, ST_YCC422, 1'b0}, 9, 2, 2, 720);
    pic_run('{FMT_HD720, R60P, ST_YCC422, 1'b0}, 4095, 2047, 1, 1280);
    pic_run('{FMT_LB2K1080, R24F, ST_GBR444, 1'b1}, 100, 1, 2, 2048);
    pat_sel = PAT_CUSTOM1;
    start(SD625, 1'b1);
    zcmd('{1'b1, 16'h1234, 1'b0, 4'h0, 16'h0, 1'b0, 1'b0});
    zp_line(12'h200, 12'h200, 1'b0);
    zcmd('{1'b0, 16'h0, 1'b1, K_X, 16'h0400, 1'b0, 1'b0});
    zp_line(12'h040, 12'h3AC, 1'b1);
    amp = 8'h00;
    zp_line(12'h1FE, 12'h202, 1'b0);
    amp = 8'hFF;
    zcmd('{1'b0, 16'h0, 1'b0, 4'h0, 16'h0, 1'b1, 1'b1});
    pat_sel = PAT_CUSTOM2;
    zp_line(12'h040, 12'h3AC, 1'b1);
    pat_sel = PAT_CUSTOM1;
    zp_line(12'h200, 12'h200, 1'b0);
    for (int p = 0; p < 6; p++) begin
      pat_sel = stp_pat_t'(p);
      amp = 8'(rnd());
      // Control writes go to the current pattern, so let the change land first
      tick();
      zcmd('{1'b1, 16'(rnd() % 2048), 1'b0, 4'h0, 16'h0, 1'b0, 1'b0});
      zp_line(zp_bound(amp, 1'b0), zp_bound(amp, 1'b1), 1'b0);
    end
    pat_sel = PAT_HSINE;
    amp = 8'hFF;
    tick();
    zcmd('{1'b1, 16'h0400, 1'b0, 4'h0, 16'h0, 1'b0, 1'b0});
    zp_line(12'h040, 12'h3AC, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
